// ### rtl/iffm_regs.vh
// Purpose: register map, field positions and reset values of the filter entry
// Assumes: plain register port, word aligned byte addresses, 32-bit data
// Notes: include once; definitions only
`ifndef IFFM_REGS_VH
`define IFFM_REGS_VH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define IFFM_ADDR_W 8
`define IFFM_OFS_CTRL 8'h00
`define IFFM_OFS_SEQ 8'h04
`define IFFM_OFS_SIP 8'h08
`define IFFM_OFS_SIP_MASK 8'h0C
`define IFFM_OFS_DIP 8'h10
`define IFFM_OFS_DIP_MASK 8'h14
`define IFFM_OFS_SPORT 8'h18
`define IFFM_OFS_DPORT 8'h1C
`define IFFM_OFS_PMODE 8'h20
`define IFFM_OFS_FLAGS 8'h24
`define IFFM_OFS_TOS 8'h28
`define IFFM_OFS_ICMP 8'h2C
`define IFFM_OFS_HITCNT 8'h30
`define IFFM_OFS_STATUS 8'h34

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define IFFM_CTRL_EN 0
`define IFFM_CTRL_ACT_LO 1
`define IFFM_CTRL_PROTO_EN 3
`define IFFM_CTRL_PROTO_LO 8
`define IFFM_PMODE_SRC_LO 0
`define IFFM_PMODE_DST_LO 2
`define IFFM_TOS_VAL_LO 8
`define IFFM_ICMP_TYPE_EN 0
`define IFFM_ICMP_CODE_EN 1
`define IFFM_ICMP_TYPE_LO 8
`define IFFM_ICMP_CODE_LO 16

// ----------------------------------------------------------------------------
// encodings
// ----------------------------------------------------------------------------
`define IFFM_PORT_ANY 2'h0
`define IFFM_PORT_SINGLE 2'h1
`define IFFM_PORT_RANGE 2'h2
`define IFFM_FLAG_DC 2'h0
`define IFFM_FLAG_SET 2'h1
`define IFFM_FLAG_UNSET 2'h2
`define IFFM_TOS_ANY 2'h0
`define IFFM_TOS_DSCP 2'h1
`define IFFM_TOS_PREC 2'h2
`define IFFM_ACT_PERMIT 2'h0
`define IFFM_ACT_DENY 2'h1
`define IFFM_ACT_SHUTDOWN 2'h2
`define IFFM_PROTO_ICMP 8'h01

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define IFFM_RST_ZERO 32'h0000_0000
`define IFFM_RST_MASK 32'hFFFF_FFFF
`define IFFM_RST_SEQ 31'h0000_0001
`define IFFM_SEQ_MAX 31'h7FFF_FFFF

`endif

// ### rtl/iffm_filter_entry.v
// Purpose: match logic of one ipv4 filter_entry against parsed frame headers
// Assumes: header fields arrive on clock_i from the ingress parser, same domain
// Notes: one result per frame_valid_i, one cycle later; registers over plain port
//
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "iffm_regs.vh"

// Behaviour
// - source range matches ports inside bounds
// - destination any ignores destination port
// - destination single needs exact port equality
// - destination range matches ports within bounds
// - urg flag set, unset or don't-care
// - ack flag set, unset or don't-care
// - psh flag set, unset or don't-care
// - rst flag set, unset or don't-care
// - syn flag set, unset or don't-care
// - fin flag set, unset or don't-care
// - tos any skips the tos byte
// - dscp mode compares six-bit dscp field
// - precedence mode compares three-bit precedence
// - icmp type any leaves type unexamined
// - icmp type number matches icmp frames only
// - icmp code any leaves code unexamined
// - icmp code value matches icmp frames only
// - sequence 1 to 2147483647, lowest first
// - deny hit drops, permit hit forwards
// - wildcard mask bit one ignores address bit
// - source any ignores source port
module iffm_filter_entry (
  input wire clock_i, // switch core clock, 125 MHz
  input wire resetn_i, // asynchronous reset, active low
  input wire [`IFFM_ADDR_W-1:0] reg_addr_i, // register byte address
  input wire [31:0] reg_wdata_i, // register write data
  input wire reg_wr_i, // register write strobe
  input wire reg_rd_i, // register read strobe
  output reg [31:0] reg_rdata_o, // read data, cycle after the strobe
  input wire frame_valid_i, // parsed header fields are valid
  input wire [31:0] frame_sip_i, // source ip address
  input wire [31:0] frame_dip_i, // destination ip address
  input wire [7:0] frame_proto_i, // ip protocol number
  input wire [15:0] frame_sport_i, // source layer-4 port
  input wire [15:0] frame_dport_i, // destination layer-4 port
  input wire [5:0] frame_tcp_flags_i, // urg ack psh rst syn fin, msb first
  input wire [7:0] frame_tos_i, // type-of-service byte
  input wire [7:0] frame_icmp_type_i, // icmp type field
  input wire [7:0] frame_icmp_code_i, // icmp code field
  output reg result_valid_o, // one-cycle pulse, verdict below is valid
  output reg result_hit_o, // frame hit this entry
  output reg result_drop_o, // hit on a deny entry, discard
  output reg result_fwd_o, // hit on a permit entry, forward and learn
  output reg result_shut_o, // hit on a shutdown entry
  output reg [30:0] result_seq_o // sequence number of this entry
);

  // --------------------------------------------------------------------------
  // helper functions
  // --------------------------------------------------------------------------

  // port criterion, used for both source and destination
  function port_ok;
    input [1:0] mode;
    input [15:0] lo;
    input [15:0] hi;
    input [15:0] port;
    begin
      case (mode)
        `IFFM_PORT_ANY: port_ok = 1'b1;
        `IFFM_PORT_SINGLE: port_ok = (port == lo);
        // lo above hi leaves the range empty, so nothing matches
        // range on either port, source or destination
        `IFFM_PORT_RANGE: port_ok = (port >= lo) && (port <= hi);
        // unused code never matches, so a bad setting fails closed
        default: port_ok = 1'b0;
      endcase
    end
  endfunction

  // three-way tcp flag criterion
  function flag_ok;
    input [1:0] mode;
    input bit_val;
    begin
      case (mode)
        `IFFM_FLAG_DC: flag_ok = 1'b1;
        `IFFM_FLAG_SET: flag_ok = bit_val;
        `IFFM_FLAG_UNSET: flag_ok = ~bit_val;
        default: flag_ok = 1'b0;
      endcase
    end
  endfunction

  // --------------------------------------------------------------------------
  // configuration registers
  // --------------------------------------------------------------------------
  reg enable_reg;
  reg [1:0] action_reg;
  reg proto_en_reg;
  reg [7:0] proto_reg;
  reg [30:0] seq_reg;
  reg [31:0] sip_reg;
  reg [31:0] sip_mask_reg;
  reg [31:0] dip_reg;
  reg [31:0] dip_mask_reg;
  reg [15:0] sport_lo_reg;
  reg [15:0] sport_hi_reg;
  reg [15:0] dport_lo_reg;
  reg [15:0] dport_hi_reg;
  reg [1:0] sport_mode_reg;
  reg [1:0] dport_mode_reg;
  reg [11:0] flag_mode_reg;
  reg [1:0] tos_mode_reg;
  reg [5:0] tos_val_reg;
  reg icmp_type_en_reg;
  reg icmp_code_en_reg;
  reg [7:0] icmp_type_reg;
  reg [7:0] icmp_code_reg;
  reg [31:0] hit_cnt_reg;
  reg last_hit_reg;
  reg last_drop_reg;

  // sequence write is clamped into the legal range, zero reads back as one
  wire [30:0] seq_next;
  assign seq_next = (reg_wdata_i[30:0] == 31'h0000_0000) ? `IFFM_RST_SEQ : reg_wdata_i[30:0];

  // software writes; reset leaves every criterion open but the entry disabled
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      enable_reg <= 1'b0;
      action_reg <= `IFFM_ACT_PERMIT;
      proto_en_reg <= 1'b0;
      proto_reg <= 8'h00;
      seq_reg <= `IFFM_RST_SEQ;
      sip_reg <= `IFFM_RST_ZERO;
      sip_mask_reg <= `IFFM_RST_MASK;
      dip_reg <= `IFFM_RST_ZERO;
      dip_mask_reg <= `IFFM_RST_MASK;
      sport_lo_reg <= 16'h0000;
      sport_hi_reg <= 16'hFFFF;
      dport_lo_reg <= 16'h0000;
      dport_hi_reg <= 16'hFFFF;
      sport_mode_reg <= `IFFM_PORT_ANY;
      dport_mode_reg <= `IFFM_PORT_ANY;
      flag_mode_reg <= 12'h000;
      tos_mode_reg <= `IFFM_TOS_ANY;
      tos_val_reg <= 6'h00;
      icmp_type_en_reg <= 1'b0;
      icmp_code_en_reg <= 1'b0;
      icmp_type_reg <= 8'h00;
      icmp_code_reg <= 8'h00;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `IFFM_OFS_CTRL: begin
          enable_reg <= reg_wdata_i[`IFFM_CTRL_EN];
          action_reg <= reg_wdata_i[`IFFM_CTRL_ACT_LO+1:`IFFM_CTRL_ACT_LO];
          proto_en_reg <= reg_wdata_i[`IFFM_CTRL_PROTO_EN];
          proto_reg <= reg_wdata_i[`IFFM_CTRL_PROTO_LO+7:`IFFM_CTRL_PROTO_LO];
        end
        `IFFM_OFS_SEQ: seq_reg <= seq_next;
        `IFFM_OFS_SIP: sip_reg <= reg_wdata_i;
        `IFFM_OFS_SIP_MASK: sip_mask_reg <= reg_wdata_i;
        `IFFM_OFS_DIP: dip_reg <= reg_wdata_i;
        `IFFM_OFS_DIP_MASK: dip_mask_reg <= reg_wdata_i;
        `IFFM_OFS_SPORT: begin
          sport_lo_reg <= reg_wdata_i[15:0];
          sport_hi_reg <= reg_wdata_i[31:16];
        end
        `IFFM_OFS_DPORT: begin
          dport_lo_reg <= reg_wdata_i[15:0];
          dport_hi_reg <= reg_wdata_i[31:16];
        end
        `IFFM_OFS_PMODE: begin
          sport_mode_reg <= reg_wdata_i[`IFFM_PMODE_SRC_LO+1:`IFFM_PMODE_SRC_LO];
          dport_mode_reg <= reg_wdata_i[`IFFM_PMODE_DST_LO+1:`IFFM_PMODE_DST_LO];
        end
        `IFFM_OFS_FLAGS: flag_mode_reg <= reg_wdata_i[11:0];
        `IFFM_OFS_TOS: begin
          tos_mode_reg <= reg_wdata_i[1:0];
          tos_val_reg <= reg_wdata_i[`IFFM_TOS_VAL_LO+5:`IFFM_TOS_VAL_LO];
        end
        `IFFM_OFS_ICMP: begin
          icmp_type_en_reg <= reg_wdata_i[`IFFM_ICMP_TYPE_EN];
          icmp_code_en_reg <= reg_wdata_i[`IFFM_ICMP_CODE_EN];
          icmp_type_reg <= reg_wdata_i[`IFFM_ICMP_TYPE_LO+7:`IFFM_ICMP_TYPE_LO];
          icmp_code_reg <= reg_wdata_i[`IFFM_ICMP_CODE_LO+7:`IFFM_ICMP_CODE_LO];
        end
        // status and unmapped offsets ignore writes; a hit count write clears the counter below
        default: ;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // match terms
  // --------------------------------------------------------------------------
  wire proto_hit;
  wire sip_hit;
  wire dip_hit;
  wire sport_hit;
  wire dport_hit;
  wire [5:0] flag_hit;
  reg tos_hit;
  wire is_icmp;
  wire icmp_type_hit;
  wire icmp_code_hit;
  wire all_hit;

  assign proto_hit = !proto_en_reg || (frame_proto_i == proto_reg);

  assign sip_hit = &(~(frame_sip_i ^ sip_reg) | sip_mask_reg);
  assign dip_hit = &(~(frame_dip_i ^ dip_reg) | dip_mask_reg);

  // port criteria through the shared function
  assign sport_hit = port_ok(sport_mode_reg, sport_lo_reg, sport_hi_reg, frame_sport_i);
  assign dport_hit = port_ok(dport_mode_reg, dport_lo_reg, dport_hi_reg, frame_dport_i);

  // one checker per tcp flag; index 5 is urg down to 0 for fin
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_flag
      assign flag_hit[gi] = flag_ok(flag_mode_reg[2*gi+1:2*gi], frame_tcp_flags_i[gi]);
    end
  endgenerate

  // type of service: dscp is the upper six bits, precedence the upper three
  // precedence mode looks only at the low three bits of the stored value
  always @* begin
    case (tos_mode_reg)
      `IFFM_TOS_ANY: tos_hit = 1'b1;
      `IFFM_TOS_DSCP: tos_hit = (frame_tos_i[7:2] == tos_val_reg);
      `IFFM_TOS_PREC: tos_hit = (frame_tos_i[7:5] == tos_val_reg[2:0]);
      default: tos_hit = 1'b0;
    endcase
  end

  // enabled icmp criteria only ever match real icmp frames; a disabled one matches any frame
  assign is_icmp = (frame_proto_i == `IFFM_PROTO_ICMP);
  assign icmp_type_hit = !icmp_type_en_reg || (is_icmp && frame_icmp_type_i == icmp_type_reg);
  assign icmp_code_hit = !icmp_code_en_reg || (is_icmp && frame_icmp_code_i == icmp_code_reg);

  assign all_hit = enable_reg && proto_hit && sip_hit && dip_hit && sport_hit && dport_hit &&
                   (&flag_hit) && tos_hit && icmp_type_hit && icmp_code_hit;

  // --------------------------------------------------------------------------
  // verdict outputs
  // --------------------------------------------------------------------------

  // registered so the forwarding logic sees a clean one-cycle result
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      result_valid_o <= 1'b0;
      result_hit_o <= 1'b0;
      result_drop_o <= 1'b0;
      result_fwd_o <= 1'b0;
      result_shut_o <= 1'b0;
      result_seq_o <= `IFFM_RST_SEQ;
    end else begin
      result_valid_o <= frame_valid_i;
      result_hit_o <= frame_valid_i && all_hit;
      result_drop_o <= frame_valid_i && all_hit && (action_reg == `IFFM_ACT_DENY);
      result_fwd_o <= frame_valid_i && all_hit && (action_reg == `IFFM_ACT_PERMIT);
      result_shut_o <= frame_valid_i && all_hit && (action_reg == `IFFM_ACT_SHUTDOWN);
      result_seq_o <= seq_reg;
    end
  end

  // a clear beside a hit wins; that hit is lost rather than half counted
  // hit counter wraps; last verdict kept for software
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hit_cnt_reg <= `IFFM_RST_ZERO;
      last_hit_reg <= 1'b0;
      last_drop_reg <= 1'b0;
    end else begin
      if (reg_wr_i && reg_addr_i == `IFFM_OFS_HITCNT) begin
        hit_cnt_reg <= `IFFM_RST_ZERO;
      end else if (frame_valid_i && all_hit) begin
        hit_cnt_reg <= hit_cnt_reg + 32'h0000_0001;
      end
      if (frame_valid_i) begin
        last_hit_reg <= all_hit;
        last_drop_reg <= all_hit && (action_reg == `IFFM_ACT_DENY);
      end
    end
  end

  // --------------------------------------------------------------------------
  // register read port
  // --------------------------------------------------------------------------

  // read data stand only in the cycle after the strobe; unmapped reads zero
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= `IFFM_RST_ZERO;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `IFFM_OFS_CTRL: reg_rdata_o <= {16'h0000, proto_reg, 4'h0, proto_en_reg,
                                        action_reg, enable_reg};
        `IFFM_OFS_SEQ: reg_rdata_o <= {1'b0, seq_reg};
        `IFFM_OFS_SIP: reg_rdata_o <= sip_reg;
        `IFFM_OFS_SIP_MASK: reg_rdata_o <= sip_mask_reg;
        `IFFM_OFS_DIP: reg_rdata_o <= dip_reg;
        `IFFM_OFS_DIP_MASK: reg_rdata_o <= dip_mask_reg;
        `IFFM_OFS_SPORT: reg_rdata_o <= {sport_hi_reg, sport_lo_reg};
        `IFFM_OFS_DPORT: reg_rdata_o <= {dport_hi_reg, dport_lo_reg};
        `IFFM_OFS_PMODE: reg_rdata_o <= {28'h000_0000, dport_mode_reg, sport_mode_reg};
        `IFFM_OFS_FLAGS: reg_rdata_o <= {20'h0_0000, flag_mode_reg};
        `IFFM_OFS_TOS: reg_rdata_o <= {18'h0_0000, tos_val_reg, 6'h00, tos_mode_reg};
        `IFFM_OFS_ICMP: reg_rdata_o <= {8'h00, icmp_code_reg, icmp_type_reg, 6'h00,
                                        icmp_code_en_reg, icmp_type_en_reg};
        `IFFM_OFS_HITCNT: reg_rdata_o <= hit_cnt_reg;
        `IFFM_OFS_STATUS: reg_rdata_o <= {30'h0000_0000, last_drop_reg, last_hit_reg};
        default: reg_rdata_o <= `IFFM_RST_ZERO;
      endcase
    end else begin
      reg_rdata_o <= `IFFM_RST_ZERO;
    end
  end

endmodule // iffm_filter_entry

// ### verif/iffm_entry_properties.sv
// Purpose: port-level checks of one filter_entry verdict and sequence outputs
// Assumes: single clock domain, resetn_i asynchronous and active low
// Notes: the enable bit is shadowed from register writes seen at the ports
`timescale 1ns/1ps
`include "iffm_regs.vh"
module iffm_entry_chk (
  input logic clock_i, // core clock
  input logic resetn_i, // reset, active low
  input logic [`IFFM_ADDR_W-1:0] reg_addr_i, // register byte address
  input logic [31:0] reg_wdata_i, // register write data
  input logic reg_wr_i, // write strobe
  input logic frame_valid_i, // parsed frame strobe
  input logic result_valid_o, // verdict strobe
  input logic result_hit_o, // entry hit
  input logic result_drop_o, // discard verdict
  input logic result_fwd_o, // forward verdict
  input logic result_shut_o, // shutdown verdict
  input logic [30:0] result_seq_o // entry sequence number
);
  // ----------------------------------------------------------------
  // helper logic
  // ----------------------------------------------------------------
  logic en_q; // enable bit as last written
  // shadow enable; a write in cycle n governs frames from n+1 on
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      en_q <= 1'b0;
    end else if (reg_wr_i && reg_addr_i == `IFFM_OFS_CTRL) begin
      en_q <= reg_wdata_i[`IFFM_CTRL_EN];
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  // verdict follows frame
  property p_res_lat; frame_valid_i |=> result_valid_o; endproperty
  a_res_lat: assert property (p_res_lat)
    else $error("no verdict one cycle after a frame");
  property p_res_idle; !frame_valid_i |=> !result_valid_o && !result_hit_o; endproperty
  a_res_idle: assert property (p_res_idle)
    else $error("verdict without a frame");
  property p_hit_gate; result_hit_o |-> result_valid_o; endproperty
  a_hit_gate: assert property (p_hit_gate)
    else $error("hit outside a verdict cycle");
  property p_deny_drop; result_drop_o |-> result_hit_o && !result_fwd_o && !result_shut_o;
  endproperty
  a_deny_drop: assert property (p_deny_drop)
    else $error("drop without a lone hit");
  property p_permit_fwd; result_fwd_o |-> result_hit_o && !result_shut_o; endproperty
  a_permit_fwd: assert property (p_permit_fwd)
    else $error("forward without a lone hit");
  property p_hit_act; result_hit_o |-> (result_drop_o || result_fwd_o || result_shut_o);
  endproperty
  a_hit_act: assert property (p_hit_act)
    else $error("hit with no action");
  property p_dis_miss; frame_valid_i && !en_q |=> !result_hit_o; endproperty
  a_dis_miss: assert property (p_dis_miss)
    else $error("disabled entry reported a hit");
  property p_seq_range; result_seq_o != 31'h0; endproperty
  a_seq_range: assert property (p_seq_range)
    else $error("sequence number is zero");
  property p_seq_hold; !reg_wr_i ##1 !reg_wr_i |=> $stable(result_seq_o); endproperty
  a_seq_hold: assert property (p_seq_hold)
    else $error("sequence changed without a write");
  c_drop: cover property (result_drop_o);
  c_fwd: cover property (result_fwd_o);
  c_shut: cover property (result_shut_o);
endmodule // iffm_entry_chk

bind iffm_filter_entry iffm_entry_chk u_chk (.clock_i(clock_i), .resetn_i(resetn_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .frame_valid_i(frame_valid_i), .result_valid_o(result_valid_o), .result_hit_o(result_hit_o),
  .result_drop_o(result_drop_o), .result_fwd_o(result_fwd_o), .result_shut_o(result_shut_o),
  .result_seq_o(result_seq_o));

// ### verif/iffm_parser_model.sv
// Purpose: ingress parser stand-in, one packed header per send strobe
// Assumes: send_i and hdr_i change just after a rising edge
// Notes: idle cycles show the inverse of the last header, never stale data
`timescale 1ns/1ps
module iffm_parser_model (
  input logic clock_i, // core clock
  input logic send_i, // present a header this cycle
  input logic [133:0] hdr_i, // packed header fields
  output logic frame_valid_o, // frame strobe to the entry
  output logic [133:0] fields_o // packed fields to the entry
);
  logic [133:0] last_q = '0; // last header sent
  // keep the last header so idle fields can be scrambled
  always @(posedge clock_i) begin
    if (send_i) begin
      last_q <= hdr_i;
    end
  end
  // fields are only meaningful in the strobe cycle
  assign frame_valid_o = send_i;
  assign fields_o = send_i ? hdr_i : ~last_q;
endmodule // iffm_parser_model

// ### verif/iffm_filter_entry_test.sv
// Purpose: self-checking bench for one ipv4 filter_entry
// Assumes: parser model feeds frames, registers over the plain port
// Notes: lfsr-built configs and frames, verdicts compared with a model
`timescale 1ns/1ps
`include "iffm_regs.vh"
module iffm_filter_entry_test;
  // ----------------------------------------------------------------
  // signals and model state
  // ----------------------------------------------------------------
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic send = 1'b0;
  logic [133:0] hdr = '0;
  logic [31:0] r = 32'h8A679D14; // lfsr state
  logic [31:0] a, c, d;
  logic [3:0] ex;
  logic [3:0] expq [$]; // expected hit, drop, fwd, shut
  logic [7:0] ra [7] = '{8'h00, 8'h04, 8'h0C, 8'h14, 8'h18, 8'h1C, 8'h3C};
  logic [31:0] re [7] = '{32'h0, 32'h1, 32'hFFFFFFFF, 32'hFFFFFFFF,
    32'hFFFF0000, 32'hFFFF0000, 32'h0};
  int cfg [12] = '{default: 0};
  int hits = 0;
  int error_cnt = 0;
  int n_checks = 0;
  wire [31:0] rdata;
  wire [30:0] seq;
  wire [133:0] f;
  wire fv, rv, hit, drop, fwd, shut;
  // clock, 8 ns period
  initial forever #4 clock_i = ~clock_i;
  iffm_parser_model u_far (.clock_i(clock_i), .send_i(send), .hdr_i(hdr),
    .frame_valid_o(fv), .fields_o(f));
  iffm_filter_entry uut (.clock_i(clock_i), .resetn_i(resetn_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .frame_valid_i(fv), .frame_sip_i(f[133:102]), .frame_dip_i(f[101:70]),
    .frame_proto_i(f[69:62]), .frame_sport_i(f[61:46]), .frame_dport_i(f[45:30]),
    .frame_tcp_flags_i(f[29:24]), .frame_tos_i(f[23:16]), .frame_icmp_type_i(f[15:8]),
    .frame_icmp_code_i(f[7:0]), .result_valid_o(rv), .result_hit_o(hit),
    .result_drop_o(drop), .result_fwd_o(fwd), .result_shut_o(shut), .result_seq_o(seq));
  // ----------------------------------------------------------------
  // helpers and reference model
  // ----------------------------------------------------------------
  // 32 shifts per draw so successive values are not just shifted copies
  function automatic void nr();
    repeat (32) r = {r[30:0], r[31] ^ r[21] ^ r[1] ^ r[0]};
  endfunction
  // port values near both ends of the 16-bit space
  function automatic logic [15:0] pv(input logic [2:0] x);
    return x[2] ? 16'hFFFC + x[1:0] : {14'h0, x[1:0]};
  endfunction
  function automatic int port_ok(int m, int w, int p);
    return m == 0 || (m == 1 && p == (w & 16'hFFFF)) ||
      (m == 2 && p >= (w & 16'hFFFF) && p <= (w >> 16));
  endfunction
  function automatic logic [3:0] expect_res(input logic [133:0] h);
    int ok, m, v;
    ok = (cfg[0] & 1) && ((h[133:102] ^ cfg[2]) & ~cfg[3]) == 0;
    ok &= ((h[101:70] ^ cfg[4]) & ~cfg[5]) == 0;
    ok &= !(cfg[0] >> 3 & 1) || h[69:62] == (cfg[0] >> 8 & 255);
    ok &= port_ok(cfg[8] & 3, cfg[6], h[61:46]) && port_ok(cfg[8] >> 2 & 3, cfg[7], h[45:30]);
    for (int i = 0; i < 6; i++) begin
      m = cfg[9] >> 2 * i & 3;
      ok &= m == 0 || (m == 1 && h[24 + i]) || (m == 2 && !h[24 + i]);
    end
    m = cfg[10] & 3;
    v = cfg[10] >> 8 & 63;
    ok &= m == 0 || (m == 1 && h[23:18] == v) || (m == 2 && h[23:21] == (v & 7));
    ok &= !(cfg[11] & 1) || (h[69:62] == 1 && h[15:8] == (cfg[11] >> 8 & 255));
    ok &= !(cfg[11] >> 1 & 1) || (h[69:62] == 1 && h[7:0] == (cfg[11] >> 16 & 255));
    v = cfg[0] >> 1 & 3;
    return {ok != 0, ok != 0 && v == 1, ok != 0 && v == 0, ok != 0 && v == 2};
  endfunction
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string s);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h expected %h", $time, s, got, exp);
    end
  endtask
  task automatic chk_res(input logic [3:0] got, input logic [3:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: verdict got %b expected %b", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] ad, input logic [31:0] dt);
    @(posedge clock_i);
    addr <= ad;
    wdata <= dt;
    wr <= 1'b1;
    @(posedge clock_i);
    wr <= 1'b0;
    if (ad < 8'h30) cfg[ad >> 2] = (ad == 8'h04 && dt == 0) ? 1 : dt;
    if (ad == 8'h30) hits = 0;
  endtask
  task automatic rd_chk(input logic [7:0] ad, input logic [31:0] exp);
    @(posedge clock_i);
    addr <= ad;
    rd <= 1'b1;
    @(posedge clock_i);
    rd <= 1'b0;
    #1 chk_val(rdata, exp, "register read");
    // read data must fall back to zero once its cycle is over
    @(posedge clock_i);
    #1 chk_val(rdata, 32'h0, "read data held too long");
  endtask
  // back-to-back frames; fields lean towards the current config
  task automatic frames(int n);
    logic [133:0] h;
    for (int i = 0; i < n; i++) begin
      nr();
      a = r;
      nr();
      h = {cfg[2] ^ (a & 31), cfg[4] ^ (a >> 5 & 31), a[10] ? 8'h01 : 8'h06,
        pv(a[13:11]), pv(a[16:14]), a[22:17],
        r[0] ? {cfg[10][10:8], cfg[10][10:8], r[2:1]} : r[10:3],
        {6'h0, r[12:11]}, {6'h0, r[14:13]}};
      @(posedge clock_i);
      send <= 1'b1;
      hdr <= h;
      expq.push_back(expect_res(h));
    end
    @(posedge clock_i);
    send <= 1'b0;
  endtask
  // verdicts checked mid-cycle, once the launching edge has settled
  always @(negedge clock_i) begin
    if (rv !== 1'b0) begin
      ex = expq.size() ? expq.pop_front() : 4'hX;
      chk_res({hit, drop, fwd, shut}, ex);
      if (ex[3] === 1'b1) hits++;
    end
  end
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  // watchdog, well beyond the roughly 6400 cycles the tests take
  initial begin
    #200000;
    error_cnt++;
    conclude();
  end
  initial begin
    repeat (4) @(posedge clock_i);
    resetn_i <= 1'b1;
    foreach (ra[i]) rd_chk(ra[i], re[i]);
    $display("test reset values done");
    wr_reg(`IFFM_OFS_SEQ, 32'h7FFFFFFF);
    rd_chk(`IFFM_OFS_SEQ, 32'h7FFFFFFF);
    chk_val({1'b0, seq}, 32'h7FFFFFFF, "sequence output");
    wr_reg(`IFFM_OFS_SEQ, 32'h0);
    rd_chk(`IFFM_OFS_SEQ, 32'h1);
    $display("test sequence done");
    // random entries, every mode and boundary port reachable
    for (int k = 0; k < 150; k++) begin
      nr();
      c = r;
      nr();
      d = r;
      wr_reg(`IFFM_OFS_CTRL, {16'h0, c[4] ? 8'h01 : 8'h06, 4'h0, c[3] & c[17],
        (c[2:1] == 2'h3) ? 2'h0 : c[2:1], c[0] | c[5]});
      wr_reg(`IFFM_OFS_SIP, d);
      wr_reg(`IFFM_OFS_SIP_MASK, c[6] ? 32'hFFFFFFFF : 32'h0000000F);
      wr_reg(`IFFM_OFS_DIP, ~d);
      wr_reg(`IFFM_OFS_DIP_MASK, c[7] ? 32'hFFFFFFFF : 32'h0000000F);
      wr_reg(`IFFM_OFS_SPORT, {pv(c[20:18]), pv(c[23:21])});
      wr_reg(`IFFM_OFS_DPORT, {pv(d[2:0]), pv(d[5:3])});
      wr_reg(`IFFM_OFS_PMODE, {28'h0, (c[13] & c[14]) ? c[11:8] : 4'h0});
      wr_reg(`IFFM_OFS_FLAGS, (c[25] & c[15]) ? {20'h0, (d[17:6] & 12'h555) << c[24]} : 32'h0);
      wr_reg(`IFFM_OFS_TOS, {18'h0, c[30:28], c[30:28], 6'h0, c[27:26] & {2{c[16]}}});
      wr_reg(`IFFM_OFS_ICMP, {14'h0, d[19:18], 6'h0, d[21:20], 6'h0, d[22] & d[23],
        d[24] & d[25]});
      wr_reg(`IFFM_OFS_HITCNT, 32'h0);
      frames(6);
      repeat (2) @(posedge clock_i);
      chk_val(expq.size(), 32'h0, "verdicts missing");
      rd_chk(`IFFM_OFS_HITCNT, hits);
      rd_chk(`IFFM_OFS_STATUS, {30'h0, ex[2], ex[3]});
      rd_chk(`IFFM_OFS_FLAGS, cfg[9]);
    end
    $display("test random entries done");
    // asynchronous reset in mid-run must bring back the open, disabled entry
    wr_reg(`IFFM_OFS_SEQ, 32'h5);
    @(posedge clock_i);
    resetn_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    resetn_i <= 1'b1;
    rd_chk(`IFFM_OFS_SEQ, 32'h1);
    chk_val({1'b0, seq}, 32'h1, "sequence output after reset");
    rd_chk(`IFFM_OFS_PMODE, 32'h0);
    rd_chk(`IFFM_OFS_HITCNT, 32'h0);
    rd_chk(`IFFM_OFS_CTRL, 32'h0);
    $display("test mid-run reset done");
    conclude();
  end
endmodule // iffm_filter_entry_test
